/* design/dlpm_pkg.sv */
package dlpm_pkg;

  // flash timing
  localparam int unsigned CLK_FREQ_HZ   = 40_000_000;
  localparam int unsigned FLASH_TIME_MS = 25;
  localparam int unsigned FLASH_CYCLES  = FLASH_TIME_MS * (CLK_FREQ_HZ / 1000);

  // widths
  localparam int SEL_W  = 8;
  localparam int GRP_W  = 4;
  localparam int DBG_W  = 8;
  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_IND1   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IND2   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_GROUP  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;

  // values after reset
  localparam logic [SEL_W-1:0] IND1_RST  = 8'h00;
  localparam logic [SEL_W-1:0] IND2_RST  = 8'h00;
  localparam logic [GRP_W-1:0] GROUP_RST = 4'h0;

  // status register field positions
  localparam int ST_IND1_BIT = 0;
  localparam int ST_IND2_BIT = 1;
  localparam int ST_GRP_LSB  = 4;
  localparam int ST_SRC1_LSB = 8;
  localparam int ST_SRC2_LSB = 16;

  typedef enum logic [GRP_W-1:0] {
    GRP_OFF      = 4'h0,
    GRP_LINK     = 4'h1,
    GRP_POWER    = 4'h2,
    GRP_CONFIG   = 4'h3,
    GRP_PIXEL    = 4'h4,
    GRP_FRONTEND = 4'h5,
    GRP_FUTURE   = 4'h6,
    GRP_SPARE    = 4'h7,
    GRP_CLOCK    = 4'h8,
    GRP_SYSBUS   = 4'h9,
    GRP_AUX      = 4'ha
  } dlpm_group_t;

  localparam logic [GRP_W-1:0] GROUP_MAX = 4'ha;

endpackage

/* design/dlpm_flash.sv */
`timescale 1ns/1ps
module dlpm_flash #(
  parameter int unsigned CYCLES = dlpm_pkg::FLASH_CYCLES
) (
  input  wire logic hclk,     // system clock
  input  wire logic hresetn,  // async reset, active low
  input  wire logic trigger,  // one-cycle start of a flash
  output logic      lit       // indicator drive, high while flashing
);
  import dlpm_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("dlpm_flash: CYCLES must be at least one");
  end

  logic [CW-1:0] count_reg;

  // each new activation reloads the full flash length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
    end else if (trigger) begin
      count_reg <= CW'(CYCLES);
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign lit = (count_reg != '0);

  flash_load_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trigger |=> lit && count_reg == CW'(CYCLES))
    else $error("flash not started at full length");

  flash_end_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(lit) |-> $past(count_reg) == CW'(1) && !$past(trigger))
    else $error("flash ended early");

endmodule

/* design/dlpm_mux.sv */
`timescale 1ns/1ps
module dlpm_mux (
  input  dlpm_pkg::dlpm_group_t      group_select,  // chosen signal group
  input  wire logic [dlpm_pkg::DBG_W-1:0] link_group,    // group 1
  input  wire logic [dlpm_pkg::DBG_W-1:0] power_group,   // group 2
  input  wire logic [dlpm_pkg::DBG_W-1:0] config_group,  // group 3
  input  wire logic [dlpm_pkg::DBG_W-1:0] pixel_group,   // group 4
  input  wire logic [dlpm_pkg::DBG_W-1:0] frontend_group,// group 5
  input  wire logic [dlpm_pkg::DBG_W-1:0] clock_group,   // group 8
  input  wire logic [dlpm_pkg::DBG_W-1:0] sysbus_group,  // group 9
  input  wire logic [dlpm_pkg::DBG_W-1:0] aux_group,     // group 10
  output logic [dlpm_pkg::DBG_W-1:0]      routed         // selected group
);
  import dlpm_pkg::*;

  always_comb begin
    unique case (group_select)
      GRP_OFF:      routed = '0;
      GRP_LINK:     routed = link_group;
      GRP_POWER:    routed = power_group;
      GRP_CONFIG:   routed = config_group;
      GRP_PIXEL:    routed = pixel_group;
      GRP_FRONTEND: routed = frontend_group;
      GRP_FUTURE:   routed = '0;
      GRP_SPARE:    routed = '0;
      GRP_CLOCK:    routed = clock_group;
      GRP_SYSBUS:   routed = sysbus_group;
      GRP_AUX:      routed = aux_group;
      default:      routed = '0;
    endcase
  end

endmodule

/* design/dlpm_top.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - two 8-bit indicator select registers, writable and readable by software.
// - selected signal going active lights its indicator for 25 ms, every time.
// - first indicator bits: bus reset, target errors 4..0, config and board requests.
// - second indicator bits: syncs, polarity, low-active power enables, clock select.
// - one chosen group of eight signals drives the debug output port.
// - debug group select takes values zero to fifteen.
// - values 0, 6, 7 and 11 to 15 leave the debug port quiet.
// - group 1 shows fiber and network port handshakes.
// - group 2 shows memory power, temperature and supply sync signals.
// - group 3 shows sequencer debug, exposure start and two-wire status.
// - group 4 shows pixel write, status, power, reset, lock and init.
// - group 5 shows front-end control and stream timing signals.
// - group 8 shows clock feeds, lock and clock-control serial lines.
// - group 9 shows system bus grants, target cycle and acknowledges.
module dlpm_top #(
  parameter int unsigned FLASH_LEN = dlpm_pkg::FLASH_CYCLES  // flash length in clocks
) (
  input  wire logic        hclk,                          // system clock, 40 MHz
  input  wire logic        hresetn,                       // async reset, active low
  input  wire logic        hsel,                          // slave select
  input  wire logic [31:0] haddr,                         // byte address
  input  wire logic [1:0]  htrans,                        // transfer type
  input  wire logic        hwrite,                        // write when high
  input  wire logic [2:0]  hsize,                         // transfer size
  input  wire logic        hready,                        // bus ready
  input  wire logic [31:0] hwdata,                        // write data
  output logic [31:0]      hrdata,                        // read data
  output logic             hreadyout,                     // slave ready
  output logic             hresp,                         // response, always okay
  input  wire logic        system_bus_reset_pulse,        // first indicator source 7
  input  wire logic [4:0]  target_error_outputs,          // first indicator sources 6..2
  input  wire logic        configuration_cycle_request,   // first indicator source 1
  input  wire logic        control_board_cycle_request,   // first indicator source 0
  input  wire logic        source_sync_output,            // second indicator source 7
  input  wire logic        sink_sync_input,               // second indicator source 6
  input  wire logic        low_supply_sync_output,        // second indicator source 5
  input  wire logic        high_voltage_polarity,         // second indicator source 4
  input  wire logic        mid_supply_power_enable_low,   // second indicator source 3
  input  wire logic        analog_supply_power_enable_low,// second indicator source 2
  input  wire logic        fan_supply_power_enable_low,   // second indicator source 1
  input  wire logic        master_clock_select_low,       // second indicator source 0
  input  wire logic [7:0]  link_group,                    // debug group 1
  input  wire logic [7:0]  power_group,                   // debug group 2
  input  wire logic [7:0]  config_group,                  // debug group 3
  input  wire logic [7:0]  pixel_group,                   // debug group 4
  input  wire logic [7:0]  frontend_group,                // debug group 5
  input  wire logic [7:0]  clock_group,                   // debug group 8
  input  wire logic [7:0]  sysbus_group,                  // debug group 9
  input  wire logic [7:0]  aux_group,                     // debug group 10
  output logic             first_indicator,               // first indicator drive
  output logic             second_indicator,              // second indicator drive
  output logic [7:0]       debug_output_port              // debug probe port
);
  import dlpm_pkg::*;

  // bus state
  logic              dp_write_reg;
  logic [ADDR_W-1:0] dp_addr_reg;
  logic              take;
  logic [31:0]       hrdata_reg;
  logic [31:0]       read_value;

  // software registers
  logic [SEL_W-1:0] ind1_sel_reg;
  logic [SEL_W-1:0] ind1_sel_next;
  logic [SEL_W-1:0] ind2_sel_reg;
  logic [SEL_W-1:0] ind2_sel_next;
  logic [GRP_W-1:0] group_reg;
  logic [GRP_W-1:0] group_next;

  // indicator sources, active high
  logic [SEL_W-1:0] src1;
  logic [SEL_W-1:0] src2;
  logic [SEL_W-1:0] src1_prev_reg;
  logic [SEL_W-1:0] src2_prev_reg;
  logic             ind1_trig;
  logic             ind2_trig;

  logic [DBG_W-1:0] routed;
  logic [DBG_W-1:0] debug_reg;

  // ---------------- bus slave ----------------
  assign take      = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= '0;
    end else begin
      dp_write_reg <= take && hwrite;
      dp_addr_reg  <= haddr[ADDR_W-1:0];
    end
  end

  // a register is only hit when the upper address bits are zero
  always_comb begin
    ind1_sel_next = ind1_sel_reg;
    ind2_sel_next = ind2_sel_reg;
    group_next    = group_reg;
    if (dp_write_reg) begin
      unique case (dp_addr_reg)
        ADDR_IND1:  ind1_sel_next = hwdata[SEL_W-1:0];
        ADDR_IND2:  ind2_sel_next = hwdata[SEL_W-1:0];
        ADDR_GROUP: group_next    = hwdata[GRP_W-1:0];
        default:    ;
      endcase
    end
  end

  logic dp_hit_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_hit_reg <= 1'b0;
    end else begin
      dp_hit_reg <= take && hwrite && (haddr[31:ADDR_W] == '0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind1_sel_reg <= IND1_RST;
      ind2_sel_reg <= IND2_RST;
      group_reg    <= GROUP_RST;
    end else if (dp_hit_reg) begin
      ind1_sel_reg <= ind1_sel_next;
      ind2_sel_reg <= ind2_sel_next;
      group_reg    <= group_next;
    end
  end

  // select and group reads see a write landing at the same edge; the status group field does not
  always_comb begin
    read_value = 32'h0000_0000;
    if (haddr[31:ADDR_W] == '0) begin
      unique case (haddr[ADDR_W-1:0])
        ADDR_IND1:  read_value[SEL_W-1:0] = dp_hit_reg ? ind1_sel_next : ind1_sel_reg;
        ADDR_IND2:  read_value[SEL_W-1:0] = dp_hit_reg ? ind2_sel_next : ind2_sel_reg;
        ADDR_GROUP: read_value[GRP_W-1:0] = dp_hit_reg ? group_next : group_reg;
        ADDR_STATUS: begin
          read_value[ST_IND1_BIT]                   = first_indicator;
          read_value[ST_IND2_BIT]                   = second_indicator;
          read_value[ST_GRP_LSB +: GRP_W]           = group_reg;
          read_value[ST_SRC1_LSB +: SEL_W]          = src1;
          read_value[ST_SRC2_LSB +: SEL_W]          = src2;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata_reg <= read_value;
    end
  end

  // ---------------- indicators ----------------
  assign src1 = {system_bus_reset_pulse, target_error_outputs,
                 configuration_cycle_request, control_board_cycle_request};
  // low-active enables and clock select count as active when low
  assign src2 = {source_sync_output, sink_sync_input, low_supply_sync_output,
                 high_voltage_polarity, !mid_supply_power_enable_low,
                 !analog_supply_power_enable_low, !fan_supply_power_enable_low,
                 !master_clock_select_low};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src1_prev_reg <= '0;
      src2_prev_reg <= '0;
    end else begin
      src1_prev_reg <= src1;
      src2_prev_reg <= src2;
    end
  end

  assign ind1_trig = |(ind1_sel_reg & src1 & ~src1_prev_reg);
  assign ind2_trig = |(ind2_sel_reg & src2 & ~src2_prev_reg);

  dlpm_flash #(.CYCLES(FLASH_LEN)) u_flash1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .trigger (ind1_trig),
    .lit     (first_indicator)
  );

  dlpm_flash #(.CYCLES(FLASH_LEN)) u_flash2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .trigger (ind2_trig),
    .lit     (second_indicator)
  );

  // ---------------- debug port ----------------
  dlpm_mux u_mux (
    .group_select   (dlpm_group_t'(group_reg)),
    .link_group     (link_group),
    .power_group    (power_group),
    .config_group   (config_group),
    .pixel_group    (pixel_group),
    .frontend_group (frontend_group),
    .clock_group    (clock_group),
    .sysbus_group   (sysbus_group),
    .aux_group      (aux_group),
    .routed         (routed)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_reg <= '0;
    end else begin
      debug_reg <= routed;
    end
  end

  assign debug_output_port = debug_reg;

  // ---------------- checks ----------------
  sel_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dp_hit_reg && dp_addr_reg == ADDR_IND1 |=> ind1_sel_reg == $past(hwdata[SEL_W-1:0]))
    else $error("first select write lost");

  sel_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr == {24'h000000, ADDR_IND2}
      |=> hrdata == {24'h000000, ind2_sel_reg})
    else $error("second select read wrong");

  ind_flash_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ind1_trig |=> first_indicator [*2])
    else $error("first indicator did not flash");

  bus_reset_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ind1_sel_reg[7] && system_bus_reset_pulse && !src1_prev_reg[7] |=> first_indicator)
    else $error("bus reset did not flash first indicator");

  fan_enable_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ind2_sel_reg[1] && !fan_supply_power_enable_low && !src2_prev_reg[1]
      |=> second_indicator)
    else $error("fan enable did not flash second indicator");

  group_store_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dp_hit_reg && dp_addr_reg == ADDR_GROUP |=> group_reg == $past(hwdata[GRP_W-1:0]))
    else $error("group select write lost");

  group_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'h0 || group_reg == 4'h6 || group_reg == 4'h7 |=> debug_output_port == '0)
    else $error("debug port not quiet");

  group_link_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'h1 |=> debug_output_port == $past(link_group))
    else $error("group 1 not routed");

  group_power_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'h2 |=> debug_output_port == $past(power_group))
    else $error("group 2 not routed");

  group_config_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'h3 |=> debug_output_port == $past(config_group))
    else $error("group 3 not routed");

  group_pixel_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'h4 |=> debug_output_port == $past(pixel_group))
    else $error("group 4 not routed");

  group_front_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'h5 |=> debug_output_port == $past(frontend_group))
    else $error("group 5 not routed");

  group_clock_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'h8 |=> debug_output_port == $past(clock_group))
    else $error("group 8 not routed");

  group_sysbus_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'h9 |=> debug_output_port == $past(sysbus_group))
    else $error("group 9 not routed");

  group_aux_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg == 4'ha |=> debug_output_port == $past(aux_group))
    else $error("group 10 not routed");

  over_range_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    group_reg > GROUP_MAX |=> debug_output_port == '0)
    else $error("out of range group not quiet");

endmodule

/* testbench/dlpm_top_tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("BAD %0t got %0h expected %0h", $time, (got), (exp)); end end

module dlpm_top_tb_top;
  import dlpm_pkg::*;
  localparam int unsigned FL    = 8;
  localparam int          LIMIT = 20000;

  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  src1    = 8'h00;
  logic [7:0]  src2    = 8'h00;
  logic [7:0]  grp [8] = '{8'h81, 8'h42, 8'h24, 8'h18, 8'hc3, 8'h3c, 8'ha5, 8'h5a};
  logic        first_indicator;
  logic        second_indicator;
  logic [7:0]  debug_output_port;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc      = 0;

  always #12.5 hclk = ~hclk;

  // src2 holds the active-high form; low-active enables are inverted at the pins
  dlpm_top #(.FLASH_LEN(FL)) DUT (
    .hclk                           (hclk),
    .hresetn                        (hresetn),
    .hsel                           (hsel),
    .haddr                          (haddr),
    .htrans                         (htrans),
    .hwrite                         (hwrite),
    .hsize                          (3'b010),
    .hready                         (hreadyout),
    .hwdata                         (hwdata),
    .hrdata                         (hrdata),
    .hreadyout                      (hreadyout),
    .hresp                          (hresp),
    .system_bus_reset_pulse         (src1[7]),
    .target_error_outputs           (src1[6:2]),
    .configuration_cycle_request    (src1[1]),
    .control_board_cycle_request    (src1[0]),
    .source_sync_output             (src2[7]),
    .sink_sync_input                (src2[6]),
    .low_supply_sync_output         (src2[5]),
    .high_voltage_polarity          (src2[4]),
    .mid_supply_power_enable_low    (~src2[3]),
    .analog_supply_power_enable_low (~src2[2]),
    .fan_supply_power_enable_low    (~src2[1]),
    .master_clock_select_low        (~src2[0]),
    .link_group                     (grp[0]),
    .power_group                    (grp[1]),
    .config_group                   (grp[2]),
    .pixel_group                    (grp[3]),
    .frontend_group                 (grp[4]),
    .clock_group                    (grp[5]),
    .sysbus_group                   (grp[6]),
    .aux_group                      (grp[7]),
    .first_indicator                (first_indicator),
    .second_indicator               (second_indicator),
    .debug_output_port              (debug_output_port)
  );

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    `CHK(hresp, 1'b0)
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask

  task automatic drive_src(input int k, input logic [7:0] v);
    @(posedge hclk);
    if (k == 1) src1 <= v;
    else src2 <= v;
  endtask

  // counts lit cycles over a window long enough for one whole flash
  task automatic measure(input int k, output int n);
    n = 0;
    repeat (FL + 4) begin
      @(negedge hclk);
      if ((k == 1 ? first_indicator : second_indicator) === 1'b1) n++;
    end
  endtask

  function automatic int gidx(input int g);
    case (g)
      1: return 0;
      2: return 1;
      3: return 2;
      4: return 3;
      5: return 4;
      8: return 5;
      9: return 6;
      10: return 7;
      default: return -1;
    endcase
  endfunction

  task automatic t_regs();
    logic [31:0] d;
    rd({24'h0, ADDR_IND1}, d);
    `CHK(d, {24'h0, IND1_RST})
    rd({24'h0, ADDR_IND2}, d);
    `CHK(d, {24'h0, IND2_RST})
    rd({24'h0, ADDR_GROUP}, d);
    `CHK(d, {28'h0, GROUP_RST})
    wr({24'h0, ADDR_IND1}, 32'hffff_ffa5);
    wr({24'h0, ADDR_IND2}, 32'h1234_565a);
    rd({24'h0, ADDR_IND1}, d);
    `CHK(d, 32'h0000_00a5)
    rd({24'h0, ADDR_IND2}, d);
    `CHK(d, 32'h0000_005a)
    // unmapped and aliased places must not touch the selects
    wr(32'h0000_0100, 32'h0000_0033);
    wr(32'h0000_0010, 32'hffff_ffff);
    rd(32'h0000_0100, d);
    `CHK(d, 32'h0)
    rd({24'h0, ADDR_IND1}, d);
    `CHK(d, 32'h0000_00a5)
    wr({24'h0, ADDR_STATUS}, 32'hffff_ffff);
    rd({24'h0, ADDR_GROUP}, d);
    `CHK(d, 32'h0)
    wr({24'h0, ADDR_IND1}, 32'h0);
    wr({24'h0, ADDR_IND2}, 32'h0);
  endtask

  task automatic t_indicators();
    int n;
    for (int k = 1; k <= 2; k++) begin
      for (int i = 0; i < 8; i++) begin
        wr(k == 1 ? {24'h0, ADDR_IND1} : {24'h0, ADDR_IND2}, 32'h1 << i);
        drive_src(k, 8'h00);
        repeat (FL + 2) @(posedge hclk);
        drive_src(k, ~(8'h01 << i));
        measure(k, n);
        `CHK(n, 0)
        drive_src(k, 8'hff);
        measure(k, n);
        `CHK(n, FL)
        measure(k, n);
        `CHK(n, 0)
        drive_src(k, 8'h00);
      end
    end
  endtask

  // second activation three cycles after the first restarts the flash
  task automatic t_retrigger();
    int          n;
    logic [31:0] d;
    wr({24'h0, ADDR_IND1}, 32'h0000_0001);
    repeat (FL + 2) @(posedge hclk);
    // status shows a running flash and both source groups
    src1 <= 8'h01;
    src2 <= 8'h0f;
    rd({24'h0, ADDR_STATUS}, d);
    `CHK(d[ST_IND1_BIT], 1'b1)
    `CHK(d[ST_IND2_BIT], 1'b0)
    `CHK(d[ST_SRC1_LSB +: SEL_W], 8'h01)
    `CHK(d[ST_SRC2_LSB +: SEL_W], 8'h0f)
    src1 <= 8'h00;
    src2 <= 8'h00;
    repeat (FL + 2) @(posedge hclk);
    n = 0;
    for (int c = 0; c < FL + 10; c++) begin
      @(posedge hclk);
      if (c == 0 || c == 3) src1 <= 8'h01;
      else if (c == 1) src1 <= 8'h00;
      @(negedge hclk);
      if (first_indicator === 1'b1) n++;
    end
    `CHK(n, FL + 3)
    @(posedge hclk);
    src1 <= 8'h00;
    wr({24'h0, ADDR_IND1}, 32'h0);
  endtask

  task automatic t_mux();
    int          gi;
    logic [7:0]  e;
    logic [7:0]  p;
    logic [31:0] d;
    for (int g = 0; g < 16; g++) begin
      gi = gidx(g);
      e = (gi < 0) ? 8'h00 : grp[gi];
      wr({24'h0, ADDR_GROUP}, 32'(g));
      rd({24'h0, ADDR_GROUP}, d);
      `CHK(d, 32'(g))
      rd({24'h0, ADDR_STATUS}, d);
      `CHK(d[7:4], 4'(g))
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      `CHK(debug_output_port, e)
      if (gi >= 0) begin
        @(posedge hclk);
        grp[gi] <= ~e;
        @(negedge hclk);
        `CHK(debug_output_port, e)
        @(negedge hclk);
        p = debug_output_port;
        `CHK(p, ~e)
        @(posedge hclk);
        grp[gi] <= e;
      end
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_indicators();
    t_retrigger();
    t_mux();
    print_verdict();
  end
endmodule
